// ==== ddp_consts.svh ====
// Timing counts, reset values and command encodings for the channel logic
`ifndef DDP_CONSTS_SVH
`define DDP_CONSTS_SVH
`define DDP_CLK_MHZ    125
`define DDP_INIT_NS    200000
`define DDP_INIT_CYC   ((`DDP_INIT_NS * `DDP_CLK_MHZ + 999) / 1000)
`define DDP_TRAIN_CYC  64
`define DDP_WR_CYC     4'h8
`define DDP_CS_IDLE    4'hf
`define DDP_RCW_NOP    3'h7
`define DDP_RCW_ACT    3'h3
`define DDP_RCW_RD     3'h5
`define DDP_RCW_WR     3'h4
`define DDP_RCW_PRE    3'h2
`define DDP_RCW_REF    3'h1
`define DDP_RCW_MRS    3'h0
`define DDP_RCW_ZQ     3'h6
`endif

// ==== ddp_dram_model.sv ====
// Behavioural memory rank model answering reads on one channel
`timescale 1ns/1ps
`default_nettype none
`include "ddp_consts.svh"
module ddp_dram_model (
	input wire logic	mem_clk,
	input wire logic [3:0]	sel_n,
	input wire logic [2:0]	rcw,
	input wire logic [15:0]	addr,
	output logic [63:0]	dq,
	output logic [8:0]	dqs,
	output logic [8:0]	dqs_n
);
	logic		lclk = 1'b0;
	logic [15:0]	a;
	initial begin
		#5;
		forever #32 lclk = ~lclk;
	end
	// --------------------
	// Read bursts
	// --------------------
	initial begin
		dq = 64'h0;
		dqs = 9'h0;
		dqs_n = 9'h1ff;
		forever begin
			@(posedge mem_clk);
			if (sel_n != 4'hf && rcw == `DDP_RCW_RD) begin
				a = addr;
				for (int k = 0; k < 2; k++) begin
					@(posedge lclk);
					dq = {4{a}} ^ {64{k[0]}};
					@(negedge lclk);
					dqs[7:0] = ~dqs[7:0];
					dqs_n[7:0] = ~dqs_n[7:0];
				end
				@(posedge lclk);
			end
			// Released data lines: keep the pattern moving
			dq = ~dq;
		end
	end
endmodule
`default_nettype wire

// ==== ddp_pkg.sv ====
// Types shared by the dual channel memory pin interface
package ddp_pkg;
	typedef enum logic [2:0] {
		DDP_NOP = 3'h0,
		DDP_ACT = 3'h1,
		DDP_RD  = 3'h2,
		DDP_WR  = 3'h3,
		DDP_PRE = 3'h4,
		DDP_REF = 3'h5,
		DDP_MRS = 3'h6,
		DDP_ZQ  = 3'h7
	} ddp_cmd_e;
	typedef enum logic [3:0] {
		ST_INIT  = 4'h1,
		ST_TRAIN = 4'h2,
		ST_IDLE  = 4'h4,
		ST_SELF  = 4'h8
	} ddp_state_e;
endpackage

// ==== ddp_top.sv ====
// Dual channel memory pin interface: channel logic and top level
`timescale 1ns/1ps
`default_nettype none
`include "ddp_consts.svh"
// Functional notes
// - Three bit bank select per channel
// - Command from strobes and write, chip-select qualified
// - Nine differential strobe pairs, crossing captures data
// - 64-bit data bus, driven only on writes
// - 16-bit address shared by row and column
// - Four clock pairs; commands change with falling edge
// - Per rank clock enable: init and power-down
// - Suspend moves all ranks into self-refresh
// - Active low select, only addressed rank asserted, all ranks at self-refresh entry
// - Four termination outputs per channel
// - Two identical independent channels A and B
// - Power-gated state holds all driven pin levels but the forwarded clocks
// - Power-gate exit skips training, resumes at once

// ----------------------------------------
// One memory channel
// ----------------------------------------
module ddp_chan import ddp_pkg::*; #(
	parameter int INIT_CYC  = `DDP_INIT_CYC,
	parameter int TRAIN_CYC = `DDP_TRAIN_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        suspend,
	input  wire logic        gated,
	input  wire logic        req_valid,
	input  wire logic [2:0]  req_cmd,
	input  wire logic [1:0]  req_rank,
	input  wire logic [2:0]  req_bank,
	input  wire logic [15:0] req_addr,
	input  wire logic [63:0] req_wdata,
	input  wire logic [3:0]  rank_pwrdn,
	output logic             req_ready,
	output logic [63:0]      rd_data,
	output logic             rd_valid,
	output logic [2:0]       bank_sel,
	output logic [15:0]      mux_addr,
	output logic             row_strobe_n,
	output logic             col_strobe_n,
	output logic             write_cmd_n,
	output logic [3:0]       rank_sel_n,
	output logic [3:0]       rank_clk_en,
	output logic [3:0]       term_ctl,
	output logic [3:0]       mem_clk,
	output logic [3:0]       mem_clk_n,
	output logic [63:0]      dq_out,
	output logic             dq_oe,
	input  wire logic [63:0] dq_in,
	output logic [8:0]       dqs_out,
	output logic [8:0]       dqs_out_n,
	output logic [8:0]       dqs_oe,
	input  wire logic [8:0]  dqs_in,
	input  wire logic [8:0]  dqs_in_n
);
	function automatic logic [2:0] rcw(input logic [2:0] c);
		case (c)
			DDP_ACT: rcw = `DDP_RCW_ACT;
			DDP_RD:  rcw = `DDP_RCW_RD;
			DDP_WR:  rcw = `DDP_RCW_WR;
			DDP_PRE: rcw = `DDP_RCW_PRE;
			DDP_REF: rcw = `DDP_RCW_REF;
			DDP_MRS: rcw = `DDP_RCW_MRS;
			DDP_ZQ:  rcw = `DDP_RCW_ZQ;
			default: rcw = `DDP_RCW_NOP;
		endcase
	endfunction

	ddp_state_e  state_q;
	logic [15:0] cnt_q;
	logic        phase_q;
	logic [3:0]  wr_cnt_q;
	logic        strobe_q;
	logic        accept;
	logic        ce;
	logic        wr_busy;
	logic [63:0] dq_s1_q;
	logic [63:0] dq_s2_q;
	logic [7:0]  dqs_s1_q;
	logic [7:0]  dqs_s2_q;
	logic [7:0]  dqsn_s1_q;
	logic [7:0]  dqsn_s2_q;
	logic [7:0]  lvl_q;
	logic [7:0]  lvl_d;

	// Commands change only when the forwarded clock is about to fall
	assign ce      = phase_q & ~gated;
	assign wr_busy = wr_cnt_q != 4'h0;
	assign accept  = req_valid & req_ready;
	assign lvl_d   = dqs_s2_q & ~dqsn_s2_q;

	// ----------------------------------------
	// Forwarded clock
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q   <= 1'b0;
			mem_clk   <= 4'h0;
			mem_clk_n <= 4'hf;
		end else begin
			phase_q   <= ~phase_q;
			mem_clk   <= {4{~phase_q}};
			mem_clk_n <= {4{phase_q}};
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_INIT;
			cnt_q   <= 16'h0;
		end else if (ce) begin
			case (state_q)
				ST_INIT: begin
					cnt_q <= cnt_q + 16'h1;
					if (cnt_q >= INIT_CYC[15:0]) begin
						state_q <= ST_TRAIN;
						cnt_q   <= 16'h0;
					end
				end
				ST_TRAIN: begin
					cnt_q <= cnt_q + 16'h1;
					if (cnt_q >= TRAIN_CYC[15:0])
						state_q <= ST_IDLE;
				end
				ST_IDLE: begin
					if (suspend && !wr_busy)
						state_q <= ST_SELF;
				end
				ST_SELF: begin
					cnt_q <= 16'h0;
					if (!suspend)
						state_q <= ST_TRAIN;
				end
				default: state_q <= ST_INIT;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			req_ready <= 1'b0;
		else
			req_ready <= ~phase_q & ~gated & ~suspend & ~wr_busy &
				(state_q == ST_IDLE) & ~accept;
	end

	// ----------------------------------------
	// Command, address and clock enable pins
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rank_sel_n   <= `DDP_CS_IDLE;
			{row_strobe_n, col_strobe_n, write_cmd_n} <= `DDP_RCW_NOP;
			bank_sel     <= 3'h0;
			mux_addr     <= 16'h0;
			rank_clk_en  <= 4'h0;
		end else if (ce) begin
			rank_sel_n <= `DDP_CS_IDLE;
			{row_strobe_n, col_strobe_n, write_cmd_n} <= `DDP_RCW_NOP;
			case (state_q)
				ST_INIT:  rank_clk_en <= {4{cnt_q >= INIT_CYC[15:0]}};
				ST_TRAIN: rank_clk_en <= 4'hf;
				ST_IDLE: begin
					rank_clk_en <= ~rank_pwrdn;
					if (suspend && !wr_busy) begin
						rank_sel_n  <= 4'h0;
						{row_strobe_n, col_strobe_n, write_cmd_n} <=
							`DDP_RCW_REF;
						rank_clk_en <= 4'h0;
					end else if (accept) begin
						rank_sel_n <= ~(4'h1 << req_rank);
						{row_strobe_n, col_strobe_n, write_cmd_n} <=
							rcw(req_cmd);
						bank_sel   <= req_bank;
						mux_addr   <= req_addr;
					end
				end
				ST_SELF:  rank_clk_en <= {4{~suspend}};
				default:  rank_clk_en <= 4'h0;
			endcase
		end
	end

	// ----------------------------------------
	// Write data, strobes and termination
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_cnt_q  <= 4'h0;
			strobe_q  <= 1'b0;
			dq_out    <= 64'h0;
			dq_oe     <= 1'b0;
			dqs_out   <= 9'h0;
			dqs_out_n <= 9'h1ff;
			dqs_oe    <= 9'h0;
			term_ctl  <= 4'h0;
		end else if (!gated) begin
			if (accept && req_cmd == DDP_WR) begin
				wr_cnt_q <= `DDP_WR_CYC;
				dq_out   <= req_wdata;
				term_ctl <= 4'h1 << req_rank;
			end else if (wr_busy) begin
				wr_cnt_q <= wr_cnt_q - 4'h1;
			end else begin
				term_ctl <= 4'h0;
			end
			strobe_q  <= wr_busy & ~strobe_q;
			dq_oe     <= wr_busy;
			dqs_oe    <= {1'b0, {8{wr_busy}}};
			dqs_out   <= {1'b0, {8{strobe_q}}};
			dqs_out_n <= {1'b1, {8{~strobe_q}}};
		end
	end

	// ----------------------------------------
	// Read capture at strobe crossings
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dq_s1_q   <= 64'h0;
			dq_s2_q   <= 64'h0;
			dqs_s1_q  <= 8'h0;
			dqs_s2_q  <= 8'h0;
			dqsn_s1_q <= 8'hff;
			dqsn_s2_q <= 8'hff;
			lvl_q     <= 8'h0;
		end else begin
			dq_s1_q   <= dq_in;
			dq_s2_q   <= dq_s1_q;
			dqs_s1_q  <= dqs_in[7:0];
			dqs_s2_q  <= dqs_s1_q;
			dqsn_s1_q <= dqs_in_n[7:0];
			dqsn_s2_q <= dqsn_s1_q;
			lvl_q     <= lvl_d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_lane
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n)
					rd_data[g*8 +: 8] <= 8'h0;
				else if (!dq_oe && lvl_d[g] != lvl_q[g])
					rd_data[g*8 +: 8] <= dq_s2_q[g*8 +: 8];
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rd_valid <= 1'b0;
		else
			rd_valid <= ~dq_oe & (lvl_d[0] != lvl_q[0]);
	end
endmodule

// ----------------------------------------
// Top level: reset release and two channels
// ----------------------------------------
module ddp_top import ddp_pkg::*; #(
	parameter int INIT_CYC  = `DDP_INIT_CYC,
	parameter int TRAIN_CYC = `DDP_TRAIN_CYC
) (
	input  wire logic        CORE_CLK,
	input  wire logic        ARST_N,
	input  wire logic        SUSPEND_TO_RAM,
	input  wire logic        IO_POWER_GATED_STATE,
	input  wire logic [1:0]  REQ_VALID,
	input  wire logic [5:0]  REQ_CMD,
	input  wire logic [3:0]  REQ_RANK,
	input  wire logic [5:0]  REQ_BANK,
	input  wire logic [31:0] REQ_ADDR,
	input  wire logic [127:0] REQ_WDATA,
	input  wire logic [7:0]  RANK_PWRDN,
	output logic [1:0]       REQ_READY,
	output logic [127:0]     RD_DATA,
	output logic [1:0]       RD_VALID,
	output logic [2:0]       CHAN_A_BANK_SEL,
	output logic [15:0]      CHAN_A_MUX_ADDR,
	output logic             CHAN_A_ROW_STROBE_N,
	output logic             CHAN_A_COL_STROBE_N,
	output logic             CHAN_A_WRITE_CMD_N,
	output logic [3:0]       CHAN_A_RANK_SEL_N,
	output logic [3:0]       CHAN_A_RANK_CLK_EN,
	output logic [3:0]       CHAN_A_TERM_CTL,
	output logic [3:0]       CHAN_A_MEM_CLK,
	output logic [3:0]       CHAN_A_MEM_CLK_N,
	output logic [63:0]      CHAN_A_DATA_BUS_O,
	output logic             CHAN_A_DATA_BUS_OE,
	input  wire logic [63:0] CHAN_A_DATA_BUS_I,
	output logic [8:0]       CHAN_A_DATA_STROBE_O,
	output logic [8:0]       CHAN_A_DATA_STROBE_N_O,
	output logic [8:0]       CHAN_A_DATA_STROBE_OE,
	input  wire logic [8:0]  CHAN_A_DATA_STROBE_I,
	input  wire logic [8:0]  CHAN_A_DATA_STROBE_N_I,
	output logic [2:0]       CHAN_B_BANK_SEL,
	output logic [15:0]      CHAN_B_MUX_ADDR,
	output logic             CHAN_B_ROW_STROBE_N,
	output logic             CHAN_B_COL_STROBE_N,
	output logic             CHAN_B_WRITE_CMD_N,
	output logic [3:0]       CHAN_B_RANK_SEL_N,
	output logic [3:0]       CHAN_B_RANK_CLK_EN,
	output logic [3:0]       CHAN_B_TERM_CTL,
	output logic [3:0]       CHAN_B_MEM_CLK,
	output logic [3:0]       CHAN_B_MEM_CLK_N,
	output logic [63:0]      CHAN_B_DATA_BUS_O,
	output logic             CHAN_B_DATA_BUS_OE,
	input  wire logic [63:0] CHAN_B_DATA_BUS_I,
	output logic [8:0]       CHAN_B_DATA_STROBE_O,
	output logic [8:0]       CHAN_B_DATA_STROBE_N_O,
	output logic [8:0]       CHAN_B_DATA_STROBE_OE,
	input  wire logic [8:0]  CHAN_B_DATA_STROBE_I,
	input  wire logic [8:0]  CHAN_B_DATA_STROBE_N_I
);
	logic [1:0] rst_sync_q;

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	ddp_chan #(.INIT_CYC(INIT_CYC), .TRAIN_CYC(TRAIN_CYC)) u_chan_a (
		.clk(CORE_CLK), .rst_n(rst_sync_q[1]),
		.suspend(SUSPEND_TO_RAM), .gated(IO_POWER_GATED_STATE),
		.req_valid(REQ_VALID[0]), .req_cmd(REQ_CMD[2:0]),
		.req_rank(REQ_RANK[1:0]), .req_bank(REQ_BANK[2:0]),
		.req_addr(REQ_ADDR[15:0]), .req_wdata(REQ_WDATA[63:0]),
		.rank_pwrdn(RANK_PWRDN[3:0]), .req_ready(REQ_READY[0]),
		.rd_data(RD_DATA[63:0]), .rd_valid(RD_VALID[0]),
		.bank_sel(CHAN_A_BANK_SEL), .mux_addr(CHAN_A_MUX_ADDR),
		.row_strobe_n(CHAN_A_ROW_STROBE_N),
		.col_strobe_n(CHAN_A_COL_STROBE_N),
		.write_cmd_n(CHAN_A_WRITE_CMD_N),
		.rank_sel_n(CHAN_A_RANK_SEL_N), .rank_clk_en(CHAN_A_RANK_CLK_EN),
		.term_ctl(CHAN_A_TERM_CTL), .mem_clk(CHAN_A_MEM_CLK),
		.mem_clk_n(CHAN_A_MEM_CLK_N), .dq_out(CHAN_A_DATA_BUS_O),
		.dq_oe(CHAN_A_DATA_BUS_OE), .dq_in(CHAN_A_DATA_BUS_I),
		.dqs_out(CHAN_A_DATA_STROBE_O), .dqs_out_n(CHAN_A_DATA_STROBE_N_O),
		.dqs_oe(CHAN_A_DATA_STROBE_OE), .dqs_in(CHAN_A_DATA_STROBE_I),
		.dqs_in_n(CHAN_A_DATA_STROBE_N_I)
	);

	ddp_chan #(.INIT_CYC(INIT_CYC), .TRAIN_CYC(TRAIN_CYC)) u_chan_b (
		.clk(CORE_CLK), .rst_n(rst_sync_q[1]),
		.suspend(SUSPEND_TO_RAM), .gated(IO_POWER_GATED_STATE),
		.req_valid(REQ_VALID[1]), .req_cmd(REQ_CMD[5:3]),
		.req_rank(REQ_RANK[3:2]), .req_bank(REQ_BANK[5:3]),
		.req_addr(REQ_ADDR[31:16]), .req_wdata(REQ_WDATA[127:64]),
		.rank_pwrdn(RANK_PWRDN[7:4]), .req_ready(REQ_READY[1]),
		.rd_data(RD_DATA[127:64]), .rd_valid(RD_VALID[1]),
		.bank_sel(CHAN_B_BANK_SEL), .mux_addr(CHAN_B_MUX_ADDR),
		.row_strobe_n(CHAN_B_ROW_STROBE_N),
		.col_strobe_n(CHAN_B_COL_STROBE_N),
		.write_cmd_n(CHAN_B_WRITE_CMD_N),
		.rank_sel_n(CHAN_B_RANK_SEL_N), .rank_clk_en(CHAN_B_RANK_CLK_EN),
		.term_ctl(CHAN_B_TERM_CTL), .mem_clk(CHAN_B_MEM_CLK),
		.mem_clk_n(CHAN_B_MEM_CLK_N), .dq_out(CHAN_B_DATA_BUS_O),
		.dq_oe(CHAN_B_DATA_BUS_OE), .dq_in(CHAN_B_DATA_BUS_I),
		.dqs_out(CHAN_B_DATA_STROBE_O), .dqs_out_n(CHAN_B_DATA_STROBE_N_O),
		.dqs_oe(CHAN_B_DATA_STROBE_OE), .dqs_in(CHAN_B_DATA_STROBE_I),
		.dqs_in_n(CHAN_B_DATA_STROBE_N_I)
	);
endmodule
`default_nettype wire

// ==== ddp_top_bench.sv ====
// Self-checking bench for the dual channel memory pin interface
`timescale 1ns/1ps
`default_nettype none
`include "ddp_consts.svh"
module ddp_top_bench import ddp_pkg::*;;
	logic CORE_CLK = 1'b0;
	logic ARST_N, SUSPEND_TO_RAM, IO_POWER_GATED_STATE;
	logic [1:0] REQ_VALID, REQ_READY, RD_VALID;
	logic [5:0] REQ_CMD, REQ_BANK;
	logic [3:0] REQ_RANK;
	logic [31:0] REQ_ADDR;
	logic [127:0] REQ_WDATA, RD_DATA;
	logic [7:0] RANK_PWRDN;
	logic CHAN_A_ROW_STROBE_N, CHAN_A_COL_STROBE_N, CHAN_A_WRITE_CMD_N;
	logic CHAN_B_ROW_STROBE_N, CHAN_B_COL_STROBE_N, CHAN_B_WRITE_CMD_N;
	logic CHAN_A_DATA_BUS_OE, CHAN_B_DATA_BUS_OE;
	logic [2:0] CHAN_A_BANK_SEL, CHAN_B_BANK_SEL;
	logic [15:0] CHAN_A_MUX_ADDR, CHAN_B_MUX_ADDR;
	logic [3:0] CHAN_A_RANK_SEL_N, CHAN_A_RANK_CLK_EN, CHAN_A_TERM_CTL;
	logic [3:0] CHAN_B_RANK_SEL_N, CHAN_B_RANK_CLK_EN, CHAN_B_TERM_CTL;
	logic [3:0] CHAN_A_MEM_CLK, CHAN_A_MEM_CLK_N, CHAN_B_MEM_CLK, CHAN_B_MEM_CLK_N;
	logic [63:0] CHAN_A_DATA_BUS_O, CHAN_A_DATA_BUS_I;
	logic [63:0] CHAN_B_DATA_BUS_O, CHAN_B_DATA_BUS_I;
	logic [8:0] CHAN_A_DATA_STROBE_O, CHAN_A_DATA_STROBE_OE;
	logic [8:0] CHAN_A_DATA_STROBE_N_O, CHAN_A_DATA_STROBE_I, CHAN_A_DATA_STROBE_N_I;
	logic [8:0] CHAN_B_DATA_STROBE_O, CHAN_B_DATA_STROBE_OE;
	logic [8:0] CHAN_B_DATA_STROBE_N_O, CHAN_B_DATA_STROBE_I, CHAN_B_DATA_STROBE_N_I;
	logic [63:0] exp_q [2][$];
	logic [63:0] p;
	int num_errors = 0;
	int samples_checked = 0;
	int n;
	localparam logic [2:0] RCW [8] = '{`DDP_RCW_NOP, `DDP_RCW_ACT, `DDP_RCW_RD,
		`DDP_RCW_WR, `DDP_RCW_PRE, `DDP_RCW_REF, `DDP_RCW_MRS, `DDP_RCW_ZQ};
	always #4 CORE_CLK = ~CORE_CLK;
	ddp_top #(.INIT_CYC(8), .TRAIN_CYC(4)) i_dut (.*);
	ddp_dram_model i_mem_a (.mem_clk(CHAN_A_MEM_CLK[0]), .sel_n(CHAN_A_RANK_SEL_N),
		.rcw({CHAN_A_ROW_STROBE_N, CHAN_A_COL_STROBE_N, CHAN_A_WRITE_CMD_N}),
		.addr(CHAN_A_MUX_ADDR), .dq(CHAN_A_DATA_BUS_I),
		.dqs(CHAN_A_DATA_STROBE_I), .dqs_n(CHAN_A_DATA_STROBE_N_I));
	ddp_dram_model i_mem_b (.mem_clk(CHAN_B_MEM_CLK[0]), .sel_n(CHAN_B_RANK_SEL_N),
		.rcw({CHAN_B_ROW_STROBE_N, CHAN_B_COL_STROBE_N, CHAN_B_WRITE_CMD_N}),
		.addr(CHAN_B_MUX_ADDR), .dq(CHAN_B_DATA_BUS_I),
		.dqs(CHAN_B_DATA_STROBE_I), .dqs_n(CHAN_B_DATA_STROBE_N_I));
	// --------------------
	// Shared tasks
	// --------------------
	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic test_done;
		$display("Checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [25:0] pins(input int ch);
		return ch ? {CHAN_B_RANK_SEL_N, CHAN_B_ROW_STROBE_N, CHAN_B_COL_STROBE_N,
			CHAN_B_WRITE_CMD_N, CHAN_B_BANK_SEL, CHAN_B_MUX_ADDR}
			: {CHAN_A_RANK_SEL_N, CHAN_A_ROW_STROBE_N, CHAN_A_COL_STROBE_N,
			CHAN_A_WRITE_CMD_N, CHAN_A_BANK_SEL, CHAN_A_MUX_ADDR};
	endfunction
	task automatic issue(input int ch, input logic [2:0] cmd);
		logic [1:0] r;
		logic [2:0] b;
		logic [15:0] a;
		logic [63:0] w;
		int i;
		r = 2'($urandom);
		b = 3'($urandom);
		a = 16'($urandom);
		w = {$urandom, $urandom};
		@(posedge CORE_CLK);
		#1 REQ_CMD[3*ch+:3] = cmd;
		REQ_RANK[2*ch+:2] = r;
		REQ_BANK[3*ch+:3] = b;
		REQ_ADDR[16*ch+:16] = a;
		REQ_WDATA[64*ch+:64] = w;
		REQ_VALID[ch] = 1'b1;
		i = 0;
		do begin
			@(posedge CORE_CLK);
			i++;
		end while (REQ_READY[ch] !== 1'b1 && i < 400);
		chk("req_ready", 128'h1, 128'(REQ_READY[ch]));
		if (cmd == DDP_RD) for (int k = 0; k < 2; k++)
			exp_q[ch].push_back({4{a}} ^ {64{k[0]}});
		#1 REQ_VALID[ch] = 1'b0;
		chk("sel_code", {~(4'h1 << r), RCW[cmd]}, pins(ch)[25:19]);
		if (cmd inside {DDP_ACT, DDP_RD, DDP_WR})
			chk("bank_addr", {b, a}, pins(ch)[18:0]);
		if (cmd == DDP_WR) begin
			@(posedge CORE_CLK);
			#1 chk("wdata", {1'b1, w}, ch ? {CHAN_B_DATA_BUS_OE,
				CHAN_B_DATA_BUS_O} : {CHAN_A_DATA_BUS_OE, CHAN_A_DATA_BUS_O});
		end
		for (i = 0; i < 100 && exp_q[ch].size() > 0; i++) @(posedge CORE_CLK);
		chk("read_beats", 128'h0, 128'(exp_q[ch].size()));
		#1;
	endtask
	// --------------------
	// Read data watcher
	// --------------------
	always @(posedge CORE_CLK) for (int c = 0; c < 2; c++) if (RD_VALID[c] === 1'b1) begin
		if (exp_q[c].size() == 0) chk("rd_valid", 128'h0, 128'h1);
		else chk("rd_data", exp_q[c].pop_front(), RD_DATA[64*c+:64]);
	end
	initial begin
		#400000;
		num_errors++;
		test_done;
	end
	// --------------------
	// Main sequence
	// --------------------
	initial begin
		{ARST_N, SUSPEND_TO_RAM, IO_POWER_GATED_STATE} = 3'h0;
		{REQ_VALID, REQ_CMD, REQ_RANK, REQ_BANK, REQ_ADDR} = '0;
		{REQ_WDATA, RANK_PWRDN} = '0;
		n = $urandom(72397);
		repeat (5) @(posedge CORE_CLK);
		#1 ARST_N = 1'b1;
		chk("reset_pins", 16'hff00, {CHAN_A_RANK_SEL_N, CHAN_B_RANK_SEL_N,
			CHAN_A_RANK_CLK_EN, CHAN_B_RANK_CLK_EN});
		for (n = 0; n < 400 && REQ_READY[0] !== 1'b1; n++) @(posedge CORE_CLK);
		#1 chk("init_cke", 8'hff, {CHAN_A_RANK_CLK_EN, CHAN_B_RANK_CLK_EN});
		for (int c = 0; c < 2; c++) for (int k = 1; k < 8; k++) issue(c, 3'(k));
		RANK_PWRDN = 8'h42;
		for (n = 0; n < 20 && CHAN_A_RANK_CLK_EN !== 4'hd; n++) @(posedge CORE_CLK);
		#1 chk("pwrdn_cke", 8'hbd, {CHAN_B_RANK_CLK_EN, CHAN_A_RANK_CLK_EN});
		RANK_PWRDN = 8'h00;
		SUSPEND_TO_RAM = 1'b1;
		for (n = 0; n < 50 && CHAN_B_RANK_CLK_EN !== 4'h0; n++) @(posedge CORE_CLK);
		#1 chk("self_cke", 8'h00, {CHAN_A_RANK_CLK_EN, CHAN_B_RANK_CLK_EN});
		SUSPEND_TO_RAM = 1'b0;
		for (n = 0; n < 200 && REQ_READY[0] !== 1'b1; n++) @(posedge CORE_CLK);
		#1 chk("wake_cke", 8'hff, {CHAN_A_RANK_CLK_EN, CHAN_B_RANK_CLK_EN});
		issue(1, DDP_RD);
		IO_POWER_GATED_STATE = 1'b1;
		repeat (3) @(posedge CORE_CLK);
		#1 p = {pins(0), pins(1), CHAN_A_RANK_CLK_EN, CHAN_B_TERM_CTL, CHAN_A_MEM_CLK};
		repeat (7) @(posedge CORE_CLK);
		#1 chk("frozen", p ^ 64'hf, {pins(0), pins(1), CHAN_A_RANK_CLK_EN,
			CHAN_B_TERM_CTL, CHAN_A_MEM_CLK});
		IO_POWER_GATED_STATE = 1'b0;
		for (n = 0; n < 6 && REQ_READY[0] !== 1'b1; n++) @(posedge CORE_CLK);
		chk("gate_exit", 128'h1, 128'(n < 6));
		issue(0, DDP_WR);
		test_done;
	end
endmodule
`default_nettype wire

// ==== ddp_top_monitor.sv ====
// Pin protocol checks for channel A of the memory pin interface
`timescale 1ns/1ps
`default_nettype none
`include "ddp_consts.svh"
module ddp_top_monitor import ddp_pkg::*; (
	input wire logic	CORE_CLK,
	input wire logic	ARST_N,
	input wire logic	SUSPEND_TO_RAM,
	input wire logic	IO_POWER_GATED_STATE,
	input wire logic [1:0]	REQ_VALID,
	input wire logic [5:0]	REQ_CMD,
	input wire logic [3:0]	REQ_RANK,
	input wire logic [5:0]	REQ_BANK,
	input wire logic [31:0]	REQ_ADDR,
	input wire logic [1:0]	REQ_READY,
	input wire logic [2:0]	CHAN_A_BANK_SEL,
	input wire logic [15:0]	CHAN_A_MUX_ADDR,
	input wire logic	CHAN_A_ROW_STROBE_N,
	input wire logic	CHAN_A_COL_STROBE_N,
	input wire logic	CHAN_A_WRITE_CMD_N,
	input wire logic [3:0]	CHAN_A_RANK_SEL_N,
	input wire logic [3:0]	CHAN_A_TERM_CTL,
	input wire logic [3:0]	CHAN_A_MEM_CLK,
	input wire logic [3:0]	CHAN_A_MEM_CLK_N,
	input wire logic	CHAN_A_DATA_BUS_OE,
	input wire logic [8:0]	CHAN_A_DATA_STROBE_O,
	input wire logic [8:0]	CHAN_A_DATA_STROBE_N_O,
	input wire logic [8:0]	CHAN_A_DATA_STROBE_OE
);
	// --------------------
	// Accepted requests
	// --------------------
	logic	acc;
	logic	wr;
	assign acc = REQ_VALID[0] && REQ_READY[0];
	assign wr = acc && REQ_CMD[2:0] == DDP_WR;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	a_sel_one_hot: assert property (acc && REQ_CMD[2:0] != DDP_NOP |=>
		CHAN_A_RANK_SEL_N == ~(4'h1 << $past(REQ_RANK[1:0])))
		else $error("rank select wrong");
	a_bank_addr: assert property (acc &&
		REQ_CMD[2:0] inside {DDP_ACT, DDP_RD, DDP_WR} |=>
		CHAN_A_BANK_SEL == $past(REQ_BANK[2:0]) &&
		CHAN_A_MUX_ADDR == $past(REQ_ADDR[15:0])) else $error("bank or addr wrong");
	a_write_code: assert property (wr |=> {CHAN_A_ROW_STROBE_N,
		CHAN_A_COL_STROBE_N, CHAN_A_WRITE_CMD_N} == `DDP_RCW_WR)
		else $error("write code wrong");
	a_cmd_deselect: assert property (acc ##2 !acc |=>
		CHAN_A_RANK_SEL_N == 4'hf) else $error("no deselect");
	a_write_window: assert property (wr |=> ##1 (CHAN_A_DATA_BUS_OE &&
		CHAN_A_DATA_STROBE_OE == 9'h0ff)[*8] ##1 !CHAN_A_DATA_BUS_OE)
		else $error("write window wrong");
	a_term_rank: assert property (wr |=>
		CHAN_A_TERM_CTL == 4'h1 << $past(REQ_RANK[1:0]))
		else $error("termination wrong");
	a_clk_fall: assert property (acc |=> CHAN_A_MEM_CLK == 4'h0 &&
		CHAN_A_MEM_CLK_N == 4'hf) else $error("clock not low at command");
	a_ready_refused: assert property (
		(SUSPEND_TO_RAM && $past(SUSPEND_TO_RAM)) ||
		(IO_POWER_GATED_STATE && $past(IO_POWER_GATED_STATE)) |->
		REQ_READY == 2'h0) else $error("ready while refused");
	a_gated_freeze: assert property (IO_POWER_GATED_STATE[*3] |->
		$stable(CHAN_A_MUX_ADDR) && $stable(CHAN_A_RANK_SEL_N))
		else $error("pins moved while gated");
	a_strobe_toggle: assert property (
		CHAN_A_DATA_BUS_OE && $past(CHAN_A_DATA_BUS_OE) |->
		CHAN_A_DATA_STROBE_O[7:0] == ~$past(CHAN_A_DATA_STROBE_O[7:0]) &&
		CHAN_A_DATA_STROBE_N_O == ~CHAN_A_DATA_STROBE_O)
		else $error("write strobe not toggling");
endmodule
bind ddp_top ddp_top_monitor i_mon (.*);
`default_nettype wire
